// ===== bench/audio_codec_model.sv
// Behavioural codec that masters bit clock and channel select.
`timescale 1ns/1ps
module audio_codec_model (
  input  wire logic        go,
  input  wire logic        lj,
  input  wire logic [15:0] rxL,
  input  wire logic [15:0] rxR,
  input  wire logic        serDataOut,
  output logic             bitClk,
  output logic             chanSel,
  output logic             serDataIn,
  output bit               gotStb,
  output logic [15:0]      gotWord
);
  logic [15:0] sh;
  int          j;
  // ==========
  // One frame per toggle of go; the clock stands still between frames.
  initial begin
    bitClk = 1'b0;
    chanSel = 1'b1;
    serDataIn = 1'b0;
    gotWord = 16'h0000;
    forever begin
      @(go);
      #3;
      for (int s = 0; s < 2; s++) begin
        chanSel = s[0];
        sh = s ? rxR : rxL;
        for (int k = 0; k < 20; k++) begin
          j = lj ? k : k - 1;
          // Outside the word the line toggles so a stale bit cannot pass.
          serDataIn = (j >= 0 && j < 16) ? sh[15-j] : ~serDataIn;
          #32 bitClk = 1'b1;
          if (j >= 0 && j < 16) gotWord[15-j] = serDataOut;
          #32 bitClk = 1'b0;
        end
        gotStb = ~gotStb;
      end
    end
  end
endmodule

// ===== bench/serial_port_audio_mode_ctrl_asserts.sv
// Port-level checks of the audio-mode serial port.
`timescale 1ns/1ps
module serial_port_audio_mode_ctrl_asserts (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        bitClk,
  input wire logic        chanSel,
  input wire logic        serDataIn,
  input wire logic        serDataOut,
  input wire logic        serDataOeN,
  input wire logic        audioActive
);
  logic [4:0] ctl_r;
  logic [3:0] since_r;
  logic       bitClk_r;
  logic       chanSel_r;
  wire        acc = psel && penable && pready && paddr[7:2] == 6'h07;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ==========
  // Shadow of the control field and cycles since the last link edge.
  always @(posedge clk_sys) begin
    bitClk_r <= bitClk;
    chanSel_r <= chanSel;
    if (!rstn) begin
      ctl_r <= 5'h00;
      since_r <= 4'hf;
    end else begin
      if (acc && pwrite) ctl_r <= pwdata[4:0];
      if ((bitClk_r && !bitClk) || chanSel_r != chanSel) since_r <= 4'h0;
      else if (since_r != 4'hf) since_r <= since_r + 4'h1;
    end
  end
  a_enable_from_write: assert property (acc && pwrite |=> audioActive == $past(pwdata[0]))
    else $error("enable differs from written bit");
  a_enable_only_write: assert property ($changed(audioActive) |-> $past(acc && pwrite))
    else $error("enable moved without a write");
  a_oe_tracks_mode: assert property (serDataOeN == !$past(audioActive))
    else $error("output enable disagrees with mode");
  a_idle_when_off: assert property (!audioActive [*3] |-> !serDataOut)
    else $error("data driven while disabled");
  a_ctl_readback: assert property (acc && !pwrite |-> prdata == {27'h000_0000, ctl_r})
    else $error("control readback wrong");
  a_reset_clears: assert property (@(posedge clk_sys) disable iff (1'b0) !rstn |=> !audioActive && !pready)
    else $error("reset left port active");
  a_quiet_mute: assert property (audioActive && (ctl_r[1] || ctl_r[2]) |-> !serDataOut)
    else $error("data sent while muted or paused");
  a_bit_launch: assert property ($changed(serDataOut) |-> since_r <= 4'h6)
    else $error("data changed away from a link edge");
endmodule
bind serial_port_audio_mode_ctrl serial_port_audio_mode_ctrl_asserts serial_port_audio_mode_ctrl_asserts_inst (
  .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bitClk(bitClk),
  .chanSel(chanSel), .serDataIn(serDataIn), .serDataOut(serDataOut), .serDataOeN(serDataOeN),
  .audioActive(audioActive));

// ===== bench/serial_port_audio_mode_ctrl_bench.sv
// Self-checking bench of the audio-mode serial port.
`timescale 1ns/1ps
`include "serial_audio_defs.vh"
module serial_port_audio_mode_ctrl_bench;
  logic        clk_sys, rstn, psel, penable, pwrite, go, lj;
  logic [7:0]  paddr;
  logic [31:0] pwdata, word, l, r;
  logic [31:0] txSw[$];
  logic [31:0] txQ[$];
  logic [32:0] apbQ[$];
  logic [32:0] apbE;
  logic [15:0] rxL, rxR;
  logic [4:0]  ctl;
  wire  [31:0] prdata;
  wire         pready, pslverr, bitClk, chanSel, serDataIn, serDataOut, serDataOeN, audioActive, gotStb;
  wire  [15:0] gotWord;
  int          mismatches, checks_done;
  logic [4:0]  ctlTab[6] = '{5'h01, 5'h11, 5'h09, 5'h03, 5'h05, 5'h1e};
  // The second setting pushes nothing, so its right slot runs the buffer dry.
  int          pushTab[6] = '{3, 0, 1, 2, 0, 0};

  serial_port_audio_mode_ctrl serial_port_audio_mode_ctrl_inst (
    .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bitClk(bitClk), .chanSel(chanSel), .serDataIn(serDataIn), .serDataOut(serDataOut),
    .serDataOeN(serDataOeN), .audioActive(audioActive));
  audio_codec_model audio_codec_model_inst (
    .go(go), .lj(lj), .rxL(rxL), .rxR(rxR), .serDataOut(serDataOut), .bitClk(bitClk),
    .chanSel(chanSel), .serDataIn(serDataIn), .gotStb(gotStb), .gotWord(gotWord));

  // ==========
  // Shared tasks.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Bit 32 of the note is the expected error flag.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    @(posedge clk_sys);
    apbQ.push_back(x);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys iff pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] pop_tx();
    return txSw.size() ? txSw.pop_front() : 32'h0000_0000;
  endfunction

  // ==========
  // Monitors.
  always @(posedge clk_sys) begin
    if (psel && penable && pready) begin
      apbE = apbQ.pop_front();
      check({31'h0, pslverr}, {31'h0, apbE[32]});
      if (!pwrite) check(prdata, apbE[31:0]);
    end
  end

  always @(gotStb) begin
    if ($time > 0) check({16'h0000, gotWord}, txQ.pop_front());
  end

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    #200us;
    mismatches++;
    complete_run();
  end

  // ==========
  // Main sequence: one codec frame per control setting.
  initial begin
    {rstn, psel, penable, pwrite, go, lj} = 6'h00;
    {paddr, pwdata, rxL, rxR} = 'h0;
    void'($urandom(98));
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    apb(1'b0, `AMC_OFS, 32'h0000_0000, 33'h0);
    apb(1'b0, 8'h40, 32'h0000_0000, {1'b1, 32'h0000_0000});
    apb(1'b1, 8'h40, $urandom, {1'b1, 32'h0000_0000});
    for (int m = 0; m < 6; m++) begin
      ctl = ctlTab[m];
      apb(1'b1, `AMC_OFS, ($urandom & 32'hffff_ffe0) | ctl, 33'h0);
      lj <= ctl[4];
      rxL <= 16'($urandom);
      rxR <= 16'($urandom);
      apb(1'b0, `AMC_OFS, 32'h0000_0000, {28'h000_0000, ctl});
      @(negedge clk_sys);
      check({31'h0, audioActive}, {31'h0, ctl[0]});
      check({31'h0, serDataOeN}, {31'h0, !ctl[0]});
      // A third word is written during the frame and must wait for space.
      for (int i = 0; i < 3; i++) begin
        if (i == 2) @(posedge clk_sys) go <= ~go;
        if (i < pushTab[m]) begin
          word = $urandom & 32'h0000_ffff;
          txSw.push_back(word);
          apb(1'b1, `TXDATA_OFS, word, 33'h0);
        end
      end
      l = (ctl[0] && !ctl[2]) ? pop_tx() : 32'h0000_0000;
      r = (ctl[0] && !ctl[2]) ? (ctl[3] ? l : pop_tx()) : 32'h0000_0000;
      txQ.push_back(ctl[1] ? 32'h0000_0000 : l);
      txQ.push_back(ctl[1] ? 32'h0000_0000 : r);
      @(gotStb);
      @(gotStb);
      if (m == 1) begin
        // Underrun stays set until written with a one; the last slot was the right one.
        word = 32'h0000_0000;
        word[`ST_TXSPACE_BIT]  = 1'b1;
        word[`ST_RXVALID_BIT]  = 1'b1;
        word[`ST_UNDERRUN_BIT] = 1'b1;
        word[`ST_CHAN_BIT]     = 1'b1;
        apb(1'b0, `STATUS_OFS, 32'h0000_0000, {1'b0, word});
        apb(1'b1, `STATUS_OFS, 32'h0000_0001 << `ST_UNDERRUN_BIT, 33'h0);
        word[`ST_UNDERRUN_BIT] = 1'b0;
        apb(1'b0, `STATUS_OFS, 32'h0000_0000, {1'b0, word});
      end
      if (ctl[0] && !ctl[2]) apb(1'b0, `RXDATA_OFS, 32'h0000_0000, {17'h0_0000, rxL});
      if (ctl[0] && !ctl[2] && !ctl[3]) apb(1'b0, `RXDATA_OFS, 32'h0000_0000, {17'h0_0000, rxR});
      apb(1'b0, `RXDATA_OFS, 32'h0000_0000, 33'h0);
    end
    complete_run();
  end
endmodule

// ===== inc/serial_audio_defs.vh
// Register map, field positions and reset values of the audio-mode serial port.
`ifndef SERIAL_AUDIO_DEFS_VH
`define SERIAL_AUDIO_DEFS_VH

// ==========================================================================
// Register byte offsets
`define AMC_OFS            8'h1c
`define TXDATA_OFS         8'h20
`define RXDATA_OFS         8'h24
`define STATUS_OFS         8'h28

// ==========================================================================
// Audio mode control fields
`define AMC_EN_BIT         0
`define AMC_MUTE_BIT       1
`define AMC_PAUSE_BIT      2
`define AMC_MONO_BIT       3
`define AMC_LJ_BIT         4
`define AMC_W              5
`define AMC_RESET          5'h0

// ==========================================================================
// Status fields
`define ST_TXSPACE_BIT     0
`define ST_RXVALID_BIT     1
`define ST_OVERRUN_BIT     2
`define ST_UNDERRUN_BIT    3
`define ST_CHAN_BIT        4

`endif

// ===== verilog/serial_port_audio_mode_ctrl.v
// Audio-mode control and serial audio engine of the serial port, with an APB register slave.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "serial_audio_defs.vh"

// Overview of operation
// - Audio serial engine runs only when enabled.
// - Standard framing: data lags channel select.
// - Left-justify: first bit with channel select.
// - Mono: each transmit word in both slots.
// - Mono: keep left receive slot, drop right.
// - Pause halts transmit and receive FIFO traffic.
// - Mute sends zero instead of transmit data.
// - Fields reset to zero; upper bits untouched.
module serial_port_audio_mode_ctrl #(
  parameter WORD_W    = 16,
  parameter CNT_W     = 5,
  parameter BUF_DEPTH = 2,
  parameter BUF_PTR_W = 1
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        bitClk,
  input  wire        chanSel,
  input  wire        serDataIn,
  output wire        serDataOut,
  output wire        serDataOeN,
  output wire        audioActive
);

  // ========================================================================
  // Constants and decode helpers

  // The bit counter is narrower than an integer, so the last index is cut on purpose.
  localparam [31:0]      LAST_BIT_WIDE = WORD_W - 1;
  localparam [CNT_W-1:0] LAST_BIT      = LAST_BIT_WIDE[CNT_W-1:0];

  // Registers are whole words, so the two low address bits take no part.
  function isReg;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      isReg = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  // ========================================================================
  // Declarations

  reg  [`AMC_W-1:0]  ctrl_r;
  reg  [31:0]        prdata_r;
  reg                pready_r;
  reg                pslverr_r;
  reg                overrun_r;
  reg                underrun_r;

  reg                sclkPrev_r;
  reg                wsPrev_r;
  reg                pendLoad_r;
  reg                pendChan_r;
  reg  [WORD_W-1:0]  txShift_r;
  reg  [WORD_W-1:0]  monoHold_r;
  reg                sdo_r;
  reg                sdoOeN_r;
  reg  [WORD_W-1:0]  rxShift_r;
  reg  [CNT_W-1:0]   rxCnt_r;
  reg                rxArm_r;
  reg                rxChan_r;

  wire [2:0]         pinSync;
  wire               sclkS = pinSync[0];
  wire               wsS   = pinSync[1];
  wire               sdiS  = pinSync[2];

  wire               txInReady;
  wire [WORD_W-1:0]  txOutData;
  wire               txOutValid;
  wire               rxInReady;
  wire [WORD_W-1:0]  rxOutData;
  wire               rxOutValid;

  // ========================================================================
  // Pin synchronisers

  // The three link pins come from the codec's clock domain, so each passes two
  // flops before any edge detector looks at it.
  sync_2ff #(
    .WIDTH (3)
  ) u_pinSync (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .asyncIn   ({serDataIn, chanSel, bitClk}),
    .syncOut_r (pinSync)
  );

  // ========================================================================
  // Effective mode bits

  // Every option is gated by the enable so a disabled port sees none of them.
  wire audioOn = ctrl_r[`AMC_EN_BIT];
  wire ljOn    = audioOn & ctrl_r[`AMC_LJ_BIT];
  wire monoOn  = audioOn & ctrl_r[`AMC_MONO_BIT];
  wire pauseOn = audioOn & ctrl_r[`AMC_PAUSE_BIT];
  wire muteOn  = audioOn & ctrl_r[`AMC_MUTE_BIT];

  // ========================================================================
  // APB decode

  wire apbAcc  = psel & penable;
  wire apbDone = apbAcc & pready_r;
  wire hitAmc  = isReg(paddr, `AMC_OFS);
  wire hitTx   = isReg(paddr, `TXDATA_OFS);
  wire hitRx   = isReg(paddr, `RXDATA_OFS);
  wire hitSt   = isReg(paddr, `STATUS_OFS);
  wire mapped  = hitAmc | hitTx | hitRx | hitSt;

  // A transmit write to a full buffer waits in the access phase instead of
  // dropping the word; this is the back-pressure towards software.
  wire txStall = hitTx & pwrite & ~txInReady;

  wire txPush  = apbDone & pwrite & hitTx;
  wire rxPop   = apbDone & ~pwrite & hitRx & rxOutValid;
  wire stWrite = apbDone & pwrite & hitSt;
  wire amcWr   = apbDone & pwrite & hitAmc;

  // Reserved bits and unmapped offsets read as zero.
  reg  [31:0] readMux;

  always @* begin
    readMux = 32'h0000_0000;
    if (hitAmc) begin
      readMux[`AMC_W-1:0] = ctrl_r;
    end else if (hitRx) begin
      readMux[WORD_W-1:0] = rxOutValid ? rxOutData : {WORD_W{1'b0}};
    end else if (hitSt) begin
      readMux[`ST_TXSPACE_BIT]  = txInReady;
      readMux[`ST_RXVALID_BIT]  = rxOutValid;
      readMux[`ST_OVERRUN_BIT]  = overrun_r;
      readMux[`ST_UNDERRUN_BIT] = underrun_r;
      readMux[`ST_CHAN_BIT]     = rxChan_r;
    end
  end

  // ========================================================================
  // APB slave and control register

  // Every transfer except a transmit write stalled on a full buffer takes one wait
  // state, so that ready, read data and error all come straight from flops.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_r    <= `AMC_RESET;
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apbAcc & ~pready_r & ~txStall;
      if (apbAcc && !pready_r && !txStall) begin
        prdata_r  <= pwrite ? 32'h0000_0000 : readMux;
        pslverr_r <= ~mapped;
      end else if (!apbAcc) begin
        prdata_r  <= 32'h0000_0000;
        pslverr_r <= 1'b0;
      end
      // Upper bits are never stored, so writes cannot disturb them.
      if (amcWr) begin
        ctrl_r <= pwdata[`AMC_W-1:0];
      end
    end
  end

  // ========================================================================
  // Transmit and receive buffers

  // Two entries let software refill one word while the other is on the wire;
  // a deeper buffer needs only a wider pointer.
  wire             rxPush;
  wire [WORD_W-1:0] rxWord = {rxShift_r[WORD_W-2:0], sdiS};
  wire             txPop;

  stream_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH),
    .PTR_W (BUF_PTR_W)
  ) u_txBuf (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .inData   (pwdata[WORD_W-1:0]),
    .inValid  (txPush),
    .inReady  (txInReady),
    .outData  (txOutData),
    .outValid (txOutValid),
    .outReady (txPop)
  );

  stream_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH),
    .PTR_W (BUF_PTR_W)
  ) u_rxBuf (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .inData   (rxWord),
    .inValid  (rxPush),
    .inReady  (rxInReady),
    .outData  (rxOutData),
    .outValid (rxOutValid),
    .outReady (rxPop)
  );

  // ========================================================================
  // Link edge detection and slot framing

  // The channel-select history resets low while the idle pin may sit high; the
  // false edge this makes after reset falls while the enable is still zero.
  wire sclkRise = sclkS & ~sclkPrev_r;
  wire sclkFall = ~sclkS & sclkPrev_r;
  wire wsEdge   = wsS ^ wsPrev_r;

  // Left-justified words start on the channel-select edge itself; standard
  // words start on the next falling bit clock, one period later.
  wire ljLoad   = wsEdge & ljOn;
  wire stdLoad  = sclkFall & pendLoad_r & ~ljOn;
  wire loadNow  = audioOn & (ljLoad | stdLoad);
  wire loadChan = ljLoad ? wsS : pendChan_r;

  // In mono the right slot repeats the left word and takes nothing new.
  wire rightRepeat = monoOn & loadChan;
  wire needPop     = loadNow & ~pauseOn & ~rightRepeat;
  assign txPop     = needPop & txOutValid;

  wire [WORD_W-1:0] freshWord = txOutValid ? txOutData : {WORD_W{1'b0}};
  wire [WORD_W-1:0] srcWord   = rightRepeat ? monoHold_r : freshWord;
  wire [WORD_W-1:0] loadWord  = (pauseOn | muteOn) ? {WORD_W{1'b0}} : srcWord;

  // Receive bits are taken on the rising bit clock, half a period after the
  // codec moved the line, which leaves the widest margin.
  // Right-slot words are dropped in mono; a paused port keeps nothing.
  wire rxDone  = audioOn & sclkRise & rxArm_r & (rxCnt_r == LAST_BIT);
  wire rxKeep  = ~pauseOn & ~(monoOn & rxChan_r);
  assign rxPush = rxDone & rxKeep;

  // ========================================================================
  // Serial engine

  always @(posedge clk_sys) begin
    if (!rstn) begin
      sclkPrev_r <= 1'b0;
      wsPrev_r   <= 1'b0;
      pendLoad_r <= 1'b0;
      pendChan_r <= 1'b0;
      txShift_r  <= {WORD_W{1'b0}};
      monoHold_r <= {WORD_W{1'b0}};
      sdo_r      <= 1'b0;
      sdoOeN_r   <= 1'b1;
      rxShift_r  <= {WORD_W{1'b0}};
      rxCnt_r    <= {CNT_W{1'b0}};
      rxArm_r    <= 1'b0;
      rxChan_r   <= 1'b0;
    end else begin
      sclkPrev_r <= sclkS;
      wsPrev_r   <= wsS;
      // The pin enable follows the control bit one cycle late, as both are flops.
      if (!audioOn) begin
        pendLoad_r <= 1'b0;
        sdo_r      <= 1'b0;
        sdoOeN_r   <= 1'b1;
        rxArm_r    <= 1'b0;
        rxCnt_r    <= {CNT_W{1'b0}};
      end else begin
        sdoOeN_r <= 1'b0;
        if (wsEdge && !ljOn) begin
          pendLoad_r <= 1'b1;
          pendChan_r <= wsS;
        end else if (stdLoad) begin
          pendLoad_r <= 1'b0;
        end
        if (loadNow) begin
          sdo_r     <= loadWord[WORD_W-1];
          txShift_r <= {loadWord[WORD_W-2:0], 1'b0};
          rxArm_r   <= 1'b1;
          rxCnt_r   <= {CNT_W{1'b0}};
          rxChan_r  <= loadChan;
          if (needPop) begin
            monoHold_r <= freshWord;
          end
        end else begin
          if (sclkFall) begin
            sdo_r     <= txShift_r[WORD_W-1];
            txShift_r <= {txShift_r[WORD_W-2:0], 1'b0};
          end
          if (sclkRise && rxArm_r) begin
            rxShift_r <= rxWord;
            rxCnt_r   <= rxCnt_r + 1'b1;
            if (rxCnt_r == LAST_BIT) begin
              rxArm_r <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ========================================================================
  // Sticky error flags

  // A new event in the clearing cycle wins over the clear.
  always @(posedge clk_sys) begin
    if (!rstn) begin
      overrun_r  <= 1'b0;
      underrun_r <= 1'b0;
    end else begin
      if (rxPush && !rxInReady) begin
        overrun_r <= 1'b1;
      end else if (stWrite && pwdata[`ST_OVERRUN_BIT]) begin
        overrun_r <= 1'b0;
      end
      if (needPop && !txOutValid) begin
        underrun_r <= 1'b1;
      end else if (stWrite && pwdata[`ST_UNDERRUN_BIT]) begin
        underrun_r <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Outputs

  // Each output is a flop, so nothing combinational reaches the pins or the bus.
  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign serDataOut  = sdo_r;
  assign serDataOeN  = sdoOeN_r;
  assign audioActive = ctrl_r[`AMC_EN_BIT];

endmodule

// ===== verilog/stream_buffer.v
// Small FIFO with valid and ready on both sides.
`timescale 1ns/1ps

module stream_buffer #(
  parameter WIDTH = 16,
  parameter DEPTH = 2,
  parameter PTR_W = 1
) (
  input  wire             clk_sys,
  input  wire             rstn,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);

  localparam [31:0]      DEPTH_FULL = DEPTH;
  localparam [31:0]      DEPTH_LAST = DEPTH - 1;
  localparam [PTR_W:0]   FULL       = DEPTH_FULL[PTR_W:0];
  localparam [PTR_W-1:0] LAST       = DEPTH_LAST[PTR_W-1:0];

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [PTR_W-1:0] wrPtr_r;
  reg [PTR_W-1:0] rdPtr_r;
  reg [PTR_W:0]   count_r;

  wire push = inValid & inReady;
  wire pop  = outValid & outReady;

  assign inReady  = (count_r != FULL);
  assign outValid = (count_r != {(PTR_W+1){1'b0}});
  assign outData  = mem_r[rdPtr_r];

  always @(posedge clk_sys) begin
    if (push) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      wrPtr_r <= {PTR_W{1'b0}};
      rdPtr_r <= {PTR_W{1'b0}};
      count_r <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == LAST) ? {PTR_W{1'b0}} : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == LAST) ? {PTR_W{1'b0}} : rdPtr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// ===== verilog/sync_2ff.v
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps

module sync_2ff #(
  parameter WIDTH = 3
) (
  input  wire             clk_sys,
  input  wire             rstn,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut_r
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      meta_r    <= {WIDTH{1'b0}};
      syncOut_r <= {WIDTH{1'b0}};
    end else begin
      meta_r    <= asyncIn;
      syncOut_r <= meta_r;
    end
  end

endmodule
